/* File: design/sjts_pkg.sv */
`default_nettype none
package sjts_pkg;

   // ****************************************************************
   // Register widths
   // ****************************************************************
   localparam int IR_W  = 3;
   localparam int ID_W  = 32;
   localparam int BSR_W = 69;

   // ****************************************************************
   // Instruction codes
   // ****************************************************************
   localparam logic [IR_W-1:0] INS_EXT_TEST = 3'h0;
   localparam logic [IR_W-1:0] INS_ID       = 3'h1;
   localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
   localparam logic [IR_W-1:0] INS_SAMPLE   = 3'h4;
   localparam logic [IR_W-1:0] INS_BYPASS   = 3'h7;
   localparam logic [IR_W-1:0] IR_CAPTURE   = 3'h1;
   localparam logic [IR_W-1:0] IR_RESET     = INS_ID;

   // ****************************************************************
   // Identification field positions
   // ****************************************************************
   localparam int ID_REV_LSB  = 29;
   localparam int ID_DEV_LSB  = 12;
   localparam int ID_VEN_LSB  = 1;
   localparam int ID_PRES_BIT = 0;
   localparam logic ID_PRESENT = 1'h1;

   // ****************************************************************
   // Controller states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_RESET   = 4'b1111,
      ST_IDLE    = 4'b1100,
      ST_SEL_DR  = 4'b0111,
      ST_CAP_DR  = 4'b0110,
      ST_SH_DR   = 4'b0010,
      ST_EX1_DR  = 4'b0001,
      ST_PAU_DR  = 4'b0011,
      ST_EX2_DR  = 4'b0000,
      ST_UPD_DR  = 4'b0101,
      ST_SEL_IR  = 4'b0100,
      ST_CAP_IR  = 4'b1110,
      ST_SH_IR   = 4'b1010,
      ST_EX1_IR  = 4'b1001,
      ST_PAU_IR  = 4'b1011,
      ST_EX2_IR  = 4'b1000,
      ST_UPD_IR  = 4'b1101
   } sjts_state_t;

   // Decoded state strobes
   typedef struct packed {
      logic resetSt;
      logic captureIr;
      logic shiftIr;
      logic updateIr;
      logic captureDr;
      logic shiftDr;
   } sjts_ctl_t;

endpackage : sjts_pkg
`default_nettype wire

/* File: design/sjts_tap_fsm.sv */
`timescale 1ns/10ps
`default_nettype none
module sjts_tap_fsm (
   // Test clock domain
   input  wire logic                tck,
   input  wire logic                tckRst,
   input  wire logic                tms,
   // Decoded state
   output var  sjts_pkg::sjts_state_t state,
   output var  sjts_pkg::sjts_ctl_t   ctl
);

   // ****************************************************************
   // Next state
   // ****************************************************************
   function automatic sjts_pkg::sjts_state_t stepState(input sjts_pkg::sjts_state_t s, input logic m);
      case (s)
         sjts_pkg::ST_RESET:  stepState = m ? sjts_pkg::ST_RESET  : sjts_pkg::ST_IDLE;
         sjts_pkg::ST_IDLE:   stepState = m ? sjts_pkg::ST_SEL_DR : sjts_pkg::ST_IDLE;
         sjts_pkg::ST_SEL_DR: stepState = m ? sjts_pkg::ST_SEL_IR : sjts_pkg::ST_CAP_DR;
         sjts_pkg::ST_CAP_DR: stepState = m ? sjts_pkg::ST_EX1_DR : sjts_pkg::ST_SH_DR;
         sjts_pkg::ST_SH_DR:  stepState = m ? sjts_pkg::ST_EX1_DR : sjts_pkg::ST_SH_DR;
         sjts_pkg::ST_EX1_DR: stepState = m ? sjts_pkg::ST_UPD_DR : sjts_pkg::ST_PAU_DR;
         sjts_pkg::ST_PAU_DR: stepState = m ? sjts_pkg::ST_EX2_DR : sjts_pkg::ST_PAU_DR;
         sjts_pkg::ST_EX2_DR: stepState = m ? sjts_pkg::ST_UPD_DR : sjts_pkg::ST_SH_DR;
         sjts_pkg::ST_UPD_DR: stepState = m ? sjts_pkg::ST_SEL_DR : sjts_pkg::ST_IDLE;
         sjts_pkg::ST_SEL_IR: stepState = m ? sjts_pkg::ST_RESET  : sjts_pkg::ST_CAP_IR;
         sjts_pkg::ST_CAP_IR: stepState = m ? sjts_pkg::ST_EX1_IR : sjts_pkg::ST_SH_IR;
         sjts_pkg::ST_SH_IR:  stepState = m ? sjts_pkg::ST_EX1_IR : sjts_pkg::ST_SH_IR;
         sjts_pkg::ST_EX1_IR: stepState = m ? sjts_pkg::ST_UPD_IR : sjts_pkg::ST_PAU_IR;
         sjts_pkg::ST_PAU_IR: stepState = m ? sjts_pkg::ST_EX2_IR : sjts_pkg::ST_PAU_IR;
         sjts_pkg::ST_EX2_IR: stepState = m ? sjts_pkg::ST_UPD_IR : sjts_pkg::ST_SH_IR;
         sjts_pkg::ST_UPD_IR: stepState = m ? sjts_pkg::ST_SEL_DR : sjts_pkg::ST_IDLE;
         default:             stepState = sjts_pkg::ST_RESET;
      endcase
   endfunction : stepState

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge tck) begin
      if (tckRst) begin
         state <= sjts_pkg::ST_RESET;
      end else begin
         state <= stepState(state, tms);
      end
   end

   always_comb begin
      ctl.resetSt   = (state == sjts_pkg::ST_RESET);
      ctl.captureIr = (state == sjts_pkg::ST_CAP_IR);
      ctl.shiftIr   = (state == sjts_pkg::ST_SH_IR);
      ctl.updateIr  = (state == sjts_pkg::ST_UPD_IR);
      ctl.captureDr = (state == sjts_pkg::ST_CAP_DR);
      ctl.shiftDr   = (state == sjts_pkg::ST_SH_DR);
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   fiveOnes_a: assert property (@(posedge tck) disable iff (tckRst)
      tms [*5] |=> state == sjts_pkg::ST_RESET)
      else $error("five mode-select highs did not reach reset");

   captureNext_a: assert property (@(posedge tck) disable iff (tckRst)
      (state == sjts_pkg::ST_SEL_DR) && !tms |=> ctl.captureDr)
      else $error("select-DR with mode low did not capture");

endmodule : sjts_tap_fsm
`default_nettype wire

/* File: design/sjts_scan.sv */
`timescale 1ns/10ps
`default_nettype none
module sjts_scan #(
   parameter int           BSR_W  = sjts_pkg::BSR_W,
   parameter logic [2:0]   ID_REV = 3'h0,      // Arbitrary value
   parameter logic [16:0]  ID_DEV = 17'h0a5a5, // Arbitrary value
   parameter logic [10:0]  ID_VEN = 11'h2b3    // Arbitrary value
) (
   // SRAM clock domain
   input  wire logic             mclk,
   input  wire logic             rst,
   // Test access pins
   input  wire logic             tck,
   input  wire logic             tms,
   input  wire logic             tdi,
   output logic                  tdo,
   output logic                  tdoEn,
   // I/O ring
   input  wire logic [BSR_W-1:0] ringIn,
   output logic                  sramHiZ
);

   // ****************************************************************
   // Decoding
   // ****************************************************************
   function automatic logic selBsr(input logic [sjts_pkg::IR_W-1:0] code);
      selBsr = (code == sjts_pkg::INS_EXT_TEST) || (code == sjts_pkg::INS_SAMPLE_Z)
               || (code == sjts_pkg::INS_SAMPLE);
   endfunction : selBsr

   function automatic logic forceHiZ(input logic [sjts_pkg::IR_W-1:0] code);
      forceHiZ = (code == sjts_pkg::INS_EXT_TEST) || (code == sjts_pkg::INS_SAMPLE_Z);
   endfunction : forceHiZ

   localparam logic [sjts_pkg::ID_W-1:0] ID_VALUE =
      ({29'h0, ID_REV} << sjts_pkg::ID_REV_LSB) | ({15'h0, ID_DEV} << sjts_pkg::ID_DEV_LSB)
      | ({21'h0, ID_VEN} << sjts_pkg::ID_VEN_LSB)
      | ({31'h0, sjts_pkg::ID_PRESENT} << sjts_pkg::ID_PRES_BIT);

   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                        rstMeta_ff;
   logic                        tckRst_ff;
   logic [BSR_W-1:0]            ringMeta_ff;
   logic [BSR_W-1:0]            ringSync_ff;
   logic [sjts_pkg::IR_W-1:0]   irSh_ff;
   logic [sjts_pkg::IR_W-1:0]   instr_ff;
   logic [sjts_pkg::ID_W-1:0]   idSh_ff;
   logic [BSR_W-1:0]            bsr_ff;
   logic                        byp_ff;
   logic                        hiZTck_ff;
   logic                        hiZMeta_ff;
   sjts_pkg::sjts_state_t       state;
   sjts_pkg::sjts_ctl_t         ctl;
   logic                        useBsr;
   logic                        useId;
   logic                        useByp;

   assign useBsr = selBsr(instr_ff);
   assign useId  = (instr_ff == sjts_pkg::INS_ID);
   assign useByp = !useBsr && !useId;

   // ****************************************************************
   // Crossings into the test clock domain
   // ****************************************************************
   always_ff @(posedge tck) begin
      rstMeta_ff <= rst;
      tckRst_ff  <= rstMeta_ff;
   end

   always_ff @(posedge tck) begin
      ringMeta_ff <= ringIn;
      ringSync_ff <= ringMeta_ff;
   end

   // ****************************************************************
   // Controller
   // ****************************************************************
   sjts_tap_fsm u_fsm (
      .tck    (tck),
      .tckRst (tckRst_ff),
      .tms    (tms),
      .state  (state),
      .ctl    (ctl)
   );

   // ****************************************************************
   // Instruction register
   // ****************************************************************
   always_ff @(posedge tck) begin
      if (tckRst_ff || ctl.captureIr) begin
         irSh_ff <= sjts_pkg::IR_CAPTURE;
      end else if (ctl.shiftIr) begin
         irSh_ff <= {tdi, irSh_ff[sjts_pkg::IR_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (tckRst_ff || ctl.resetSt) begin
         instr_ff <= sjts_pkg::IR_RESET;
      end else if (ctl.updateIr) begin
         instr_ff <= irSh_ff;
      end
   end

   // ****************************************************************
   // Data registers
   // ****************************************************************
   always_ff @(posedge tck) begin
      if (tckRst_ff) begin
         idSh_ff <= ID_VALUE;
      end else if (ctl.captureDr && useId) begin
         idSh_ff <= ID_VALUE;
      end else if (ctl.shiftDr && useId) begin
         idSh_ff <= {tdi, idSh_ff[sjts_pkg::ID_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (tckRst_ff) begin
         bsr_ff <= '0;
      end else if (ctl.captureDr && useBsr) begin
         bsr_ff <= ringSync_ff;
      end else if (ctl.shiftDr && useBsr) begin
         bsr_ff <= {tdi, bsr_ff[BSR_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (tckRst_ff || (ctl.captureDr && useByp)) begin
         byp_ff <= 1'h0;
      end else if (ctl.shiftDr && useByp) begin
         byp_ff <= tdi;
      end
   end

   // ****************************************************************
   // Serial output on the falling edge
   // ****************************************************************
   always_ff @(negedge tck) begin
      if (tckRst_ff) begin
         tdo   <= 1'h0;
         tdoEn <= 1'h0;
      end else begin
         tdoEn <= ctl.shiftIr || ctl.shiftDr;
         if (ctl.shiftIr) begin
            tdo <= irSh_ff[0];
         end else if (useBsr) begin
            tdo <= bsr_ff[0];
         end else if (useId) begin
            tdo <= idSh_ff[0];
         end else begin
            tdo <= byp_ff;
         end
      end
   end

   // ****************************************************************
   // Output high-Z control into the SRAM clock domain
   // ****************************************************************
   always_ff @(posedge tck) begin
      // Loaded with the instruction, so a test clock that stops after Update-IR still takes effect
      if (tckRst_ff || ctl.resetSt) begin
         hiZTck_ff <= 1'h0;
      end else if (ctl.updateIr) begin
         hiZTck_ff <= forceHiZ(irSh_ff);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hiZMeta_ff <= 1'h0;
         sramHiZ    <= 1'h0;
      end else begin
         hiZMeta_ff <= hiZTck_ff;
         sramHiZ    <= hiZMeta_ff;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence irLoad_s;
      ctl.shiftIr ##1 (state == sjts_pkg::ST_EX1_IR) ##1 ctl.updateIr;
   endsequence

   sequence bsrCapShift_s;
      ctl.captureDr && useBsr ##1 ctl.shiftDr;
   endsequence

   resetInstr_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.resetSt |=> instr_ff == sjts_pkg::INS_ID)
      else $error("reset state did not select the ID instruction");

   updateInstr_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      irLoad_s |=> instr_ff == $past(irSh_ff))
      else $error("update did not load the shifted instruction");

   instrHold_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      !ctl.updateIr && !ctl.resetSt |=> $stable(instr_ff))
      else $error("instruction changed outside update");

   idLoad_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.captureDr && useId |=> idSh_ff[sjts_pkg::ID_W-1:1] == {ID_REV, ID_DEV, ID_VEN})
      else $error("ID capture loaded the wrong fields");

   idPresent_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.captureDr && useId |=> idSh_ff[sjts_pkg::ID_PRES_BIT] == 1'h1)
      else $error("ID presence bit not one");

   bsrCapture_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.captureDr && useBsr |=> bsr_ff == $past(ringSync_ff))
      else $error("boundary register missed the ring capture");

   bsrShift_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      bsrCapShift_s |=> bsr_ff[BSR_W-1] == $past(tdi) && bsr_ff[BSR_W-2:0] == $past(bsr_ff[BSR_W-1:1]))
      else $error("boundary shift direction wrong");

   bypassZero_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.captureDr && useByp ##1 ctl.shiftDr |-> byp_ff == 1'h0)
      else $error("bypass did not capture zero");

   tdoEnable_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.shiftIr || ctl.shiftDr |-> tdoEn)
      else $error("serial output not enabled while shifting");

   hiZDrive_a: assert property (@(posedge mclk) disable iff (rst)
      hiZTck_ff [*4] |-> sramHiZ)
      else $error("high-Z request did not reach the SRAM side");

   hiZRelease_a: assert property (@(posedge mclk) disable iff (rst)
      !hiZTck_ff [*4] |-> !sramHiZ)
      else $error("outputs held high-Z without request");

   hiZCode_a: assert property (@(posedge tck) disable iff (tckRst_ff)
      ctl.updateIr && irSh_ff == sjts_pkg::INS_SAMPLE_Z |=> hiZTck_ff)
      else $error("sample-Z code did not request high-Z");

endmodule : sjts_scan
`default_nettype wire

/* File: verif/sjts_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sjts_ctrl_model (
   // Test access pins
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   logic run;

   // ***************************************************************
   // Test clock, still outside frames
   // ***************************************************************
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
      run = 1'h0;
      #3.7;
      forever begin
         #40;
         if (run || tck) begin
            tck = ~tck;
         end
      end
   end

   // ***************************************************************
   // One controller step
   // ***************************************************************
   task automatic step(input logic tmsV, input logic tdiV, output logic tdoV);
      run = 1'h1;
      @(negedge tck);
      tms <= tmsV;
      tdi <= tdiV;
      @(posedge tck);
      tdoV = tdo;
   endtask : step

   // Five ones reach reset, then idle
   task automatic tlr();
      logic d;
      repeat (5) step(1'h1, ~tdi, d);
      step(1'h0, ~tdi, d);
      run = 1'h0;
   endtask : tlr

   // Instruction load from idle, back to idle
   task automatic loadIr(input logic [2:0] code, output logic [2:0] cap);
      logic d;
      step(1'h1, ~tdi, d);
      step(1'h1, ~tdi, d);
      step(1'h0, ~tdi, d);
      step(1'h0, ~tdi, d);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, code[i], cap[i]);
      end
      step(1'h1, ~tdi, d);
      step(1'h0, ~tdi, d);
      run = 1'h0;
   endtask : loadIr

   // Data scan of n bits from idle, back to idle
   task automatic scanDr(input int n, input logic [79:0] din, output logic [79:0] dout);
      logic d;
      dout = 80'h0;
      step(1'h1, ~tdi, d);
      step(1'h0, ~tdi, d);
      step(1'h0, ~tdi, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'h1, ~tdi, d);
      step(1'h0, ~tdi, d);
      run = 1'h0;
   endtask : scanDr
endmodule : sjts_ctrl_model
`default_nettype wire

/* File: verif/sjts_scan_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin miscompares++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sjts_scan_bench;
   localparam logic [2:0]  REV = 3'h5;     // Arbitrary value
   localparam logic [16:0] DEV = 17'h1c3a9; // Arbitrary value
   localparam logic [10:0] VEN = 11'h4d2;   // Arbitrary value
   localparam logic [68:0] PAT = 69'h0f_3c5a_96e1_d2b4_870c;

   logic                          mclk;
   logic                          rst;
   logic                          tck;
   logic                          tms;
   logic                          tdi;
   logic                          tdo;
   logic                          tdoEn;
   logic                          sramHiZ;
   logic [sjts_pkg::BSR_W-1:0]    ringIn;
   logic [79:0]                   o;
   logic [2:0]                    cap;
   int                            miscompares;
   int                            numChecks;

   initial mclk = 1'h0;
   always #2.5 mclk = ~mclk;

   sjts_scan #(.BSR_W(sjts_pkg::BSR_W), .ID_REV(REV), .ID_DEV(DEV), .ID_VEN(VEN)) sjts_scan_i (
      .mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdoEn(tdoEn), .ringIn(ringIn), .sramHiZ(sramHiZ));
   sjts_ctrl_model sjts_ctrl_model_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   // ***************************************************************
   // Helpers
   // ***************************************************************
   task report_and_stop();
      if (miscompares == 0 && numChecks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task waitHiZ(input logic exp);
      int k;
      k = 0;
      while (sramHiZ !== exp && k < 60) begin
         @(posedge mclk);
         k++;
      end
      if (k == 60) begin
         miscompares++;
         report_and_stop();
      end
   endtask : waitHiZ

   task load(input logic [2:0] code);
      sjts_ctrl_model_i.loadIr(code, cap);
      `CHK(cap, sjts_pkg::IR_CAPTURE)
   endtask : load

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task t_id();
      sjts_ctrl_model_i.scanDr(36, 80'ha, o);
      `CHK(o[31:29], REV)
      `CHK(o[28:12], DEV)
      `CHK(o[11:1], VEN)
      `CHK(o[0], 1'h1)
      `CHK(o[35:32], 4'ha)
      `CHK(sramHiZ, 1'h0)
      `CHK(tdoEn, 1'h0)
   endtask : t_id

   task t_ring(input logic [2:0] code, input logic hz);
      @(posedge mclk);
      ringIn <= PAT ^ {66'h0, code};
      load(code);
      waitHiZ(hz);
      `CHK(sramHiZ, hz)
      sjts_ctrl_model_i.scanDr(74, 80'h15, o);
      `CHK(o[68:0], PAT ^ {66'h0, code})
      `CHK(o[73:69], 5'h15)
   endtask : t_ring

   task t_bypass();
      load(sjts_pkg::INS_BYPASS);
      sjts_ctrl_model_i.scanDr(8, 80'h5b, o);
      `CHK(o[7:0], 8'hb6)
      `CHK(sramHiZ, 1'h0)
   endtask : t_bypass

   task t_reset();
      load(sjts_pkg::INS_EXT_TEST);
      waitHiZ(1'h1);
      sjts_ctrl_model_i.tlr();
      waitHiZ(1'h0);
      `CHK(sramHiZ, 1'h0)
      t_id();
   endtask : t_reset

   // ***************************************************************
   // Main sequence, only defined codes are loaded
   // ***************************************************************
   initial begin
      rst = 1'h1;
      ringIn = 69'h0;
      miscompares = 0;
      numChecks = 0;
      repeat (8) @(posedge mclk);
      sjts_ctrl_model_i.tlr();
      @(posedge mclk);
      rst <= 1'h0;
      sjts_ctrl_model_i.tlr();
      t_id();
      t_ring(sjts_pkg::INS_EXT_TEST, 1'h1);
      t_ring(sjts_pkg::INS_SAMPLE, 1'h0);
      t_ring(sjts_pkg::INS_SAMPLE_Z, 1'h1);
      load(sjts_pkg::INS_ID);
      waitHiZ(1'h0);
      t_id();
      t_bypass();
      t_reset();
      report_and_stop();
   end

   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
endmodule : sjts_scan_bench
`default_nettype wire
